// ==== usb_bufsel_top.sv ====
// buffer selector with status write-back and device reset exit
`timescale 1ns/1ps
`default_nettype none
module usb_bufsel_top
#(
  parameter int RESET_CYC = usb_bufsel_pkg::RESET_SE0_CYC,
  parameter int IDLE_CYC  = usb_bufsel_pkg::IDLE_J_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        dp_in,
  input  wire logic        dm_in,
  input  wire logic        pkt_done,
  input  wire logic        pkt_in,
  input  wire logic [15:0] pkt_status,
  input  wire logic [3:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  output logic             irq,
  output logic             pkt_accept,
  output logic             buf_sel,
  output logic      [15:0] buf_info,
  output logic      [6:0]  max_pkt
);
  import usb_bufsel_pkg::*;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [1:0] dp_s_r;
  logic [1:0] dm_s_r;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dp_s_r <= 2'h3; // idle level is J, so no false SE0 after reset
      dm_s_r <= 2'h0;
    end else begin
      dp_s_r <= {dp_s_r[0], dp_in};
      dm_s_r <= {dm_s_r[0], dm_in};
    end
  end
  logic j_state;
  logic se0;
  assign j_state = dp_s_r[1] && !dm_s_r[1];
  assign se0     = !dp_s_r[1] && !dm_s_r[1];

  // ----------------------------------------
  // line condition timers
  // ----------------------------------------
  logic se0_long;
  logic idle_long;
  usb_idle_timer #(.LIMIT(RESET_CYC), .W(CNT_W + 2)) u_se0 (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .cond    (se0),
    .done    (se0_long)
  );
  logic wait_j;
  usb_idle_timer #(.LIMIT(IDLE_CYC), .W(CNT_W)) u_idle (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .cond    (wait_j),
    .done    (idle_long)
  );

  // ----------------------------------------
  // device state
  // ----------------------------------------
  dev_state_t st_r;
  dev_state_t st_nxt;
  logic       ev_reset;
  logic       ev_conn;
  always_comb begin
    st_nxt   = st_r;
    ev_reset = 1'b0;
    ev_conn  = 1'b0;
    unique case (st_r)
      DEV_CONNECTED: begin
        if (se0_long) begin
          st_nxt   = DEV_RESET;
          ev_reset = 1'b1;
        end
      end
      DEV_RESET: begin
        if (!se0) begin
          st_nxt = DEV_WAIT_IDLE;
        end
      end
      DEV_WAIT_IDLE: begin
        if (se0_long) begin
          st_nxt   = DEV_RESET;
          ev_reset = 1'b1;
        end else if (idle_long) begin
          st_nxt  = DEV_CONNECTED;
          ev_conn = 1'b1;
        end
      end
      default: begin
        st_nxt = DEV_RESET;
      end
    endcase
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= DEV_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign wait_j = (st_r == DEV_WAIT_IDLE) && j_state;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0]  stat_r, stat_nxt;
  logic [7:0]  mask_r, mask_nxt;
  logic [2:0]  ctrl_r, ctrl_nxt;
  logic [31:0] ep_r, ep_nxt;
  logic [1:0]  attn_r, attn_nxt;
  logic [15:0] bc0_r, bc0_nxt;
  logic [15:0] bc1_r, bc1_nxt;
  logic        sel_r, sel_nxt;
  logic [31:0] rdata_nxt;
  logic        done_ok;
  logic [7:0]  ev;
  assign done_ok = pkt_done && ctrl_r[CTRL_HOST_BIT];
  assign ev = (ev_reset ? INT_RESET_BIT : 8'h00) | (ev_conn ? INT_CONN_BIT : 8'h00)
            | (done_ok ? INT_DONE_BIT : 8'h00);
  always_comb begin
    stat_nxt = stat_r;
    mask_nxt = mask_r;
    ctrl_nxt = ctrl_r;
    ep_nxt   = ep_r;
    attn_nxt = attn_r;
    bc0_nxt  = bc0_r;
    bc1_nxt  = bc1_r;
    sel_nxt  = sel_r;
    rdata_nxt = 32'h0;
    if (wr) begin
      unique case (addr)
        ADDR_STATUS:  stat_nxt = stat_r & ~wdata[7:0];
        ADDR_MASK:    mask_nxt = wdata[7:0];
        ADDR_CTRL:    ctrl_nxt = wdata[2:0];
        ADDR_EP_STAT: ep_nxt   = ep_r & ~wdata;
        ADDR_ATTN:    attn_nxt = attn_r & ~wdata[1:0];
        ADDR_BUFCTL0: bc0_nxt  = wdata[15:0];
        ADDR_BUFCTL1: bc1_nxt  = wdata[15:0];
        default: begin
        end
      endcase
    end
    if (rd) begin
      unique case (addr)
        ADDR_STATUS:  rdata_nxt = {24'h0, stat_r};
        ADDR_MASK:    rdata_nxt = {24'h0, mask_r};
        ADDR_CTRL:    rdata_nxt = {29'h0, ctrl_r};
        ADDR_EP_STAT: rdata_nxt = ep_r;
        ADDR_ATTN:    rdata_nxt = {30'h0, attn_r};
        ADDR_STATE:   rdata_nxt = {29'h0, sel_r, st_r};
        ADDR_BUFCTL0: rdata_nxt = {16'h0, bc0_r};
        ADDR_BUFCTL1: rdata_nxt = {16'h0, bc1_r};
        default:      rdata_nxt = 32'h0;
      endcase
    end
    if (done_ok) begin
      if (sel_r) begin
        ep_nxt[HALF_SHIFT +: STAT_W] = pkt_status;
      end else begin
        ep_nxt[0 +: STAT_W] = pkt_status;
      end
      attn_nxt[sel_r] = 1'b1;
      sel_nxt = ~sel_r;
    end
    if (ev_reset) begin
      sel_nxt = 1'b0;
    end
    stat_nxt = stat_nxt | ev;
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_r <= 8'h00;
      mask_r <= 8'h00;
      ctrl_r <= 3'h0;
      ep_r   <= 32'h0;
      attn_r <= 2'h0;
      bc0_r  <= 16'h0;
      bc1_r  <= 16'h0;
      sel_r  <= 1'b0;
      rdata  <= 32'h0;
    end else begin
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      ctrl_r <= ctrl_nxt;
      ep_r   <= ep_nxt;
      attn_r <= attn_nxt;
      bc0_r  <= bc0_nxt;
      bc1_r  <= bc1_nxt;
      sel_r  <= sel_nxt;
      rdata  <= rdata_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq        <= 1'b0;
      pkt_accept <= 1'b0;
      buf_sel    <= 1'b0;
      buf_info   <= 16'h0;
      max_pkt    <= 7'h0;
    end else begin
      irq        <= |(stat_nxt & mask_nxt);
      pkt_accept <= (st_nxt == DEV_CONNECTED) && pkt_in;
      buf_sel    <= sel_nxt;
      buf_info   <= (ctrl_nxt[CTRL_DBL_BIT] && sel_nxt) ? bc1_nxt : bc0_nxt;
      max_pkt    <= ctrl_nxt[CTRL_LS_BIT] ? 7'(LS_MAX_PKT) : 7'(FS_MAX_PKT);
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sel_toggle_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    done_ok && !ev_reset |=> sel_r != $past(sel_r))
    else $error("select did not toggle");
  upper_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    done_ok && sel_r |=> ep_r[31:16] == $past(pkt_status))
    else $error("upper half not written");
  lower_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    done_ok && !sel_r |=> ep_r[15:0] == $past(pkt_status))
    else $error("lower half not written");
  attn_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    done_ok |=> attn_r[$past(sel_r)])
    else $error("attention flag missing");
  single_fetch_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !ctrl_r[CTRL_DBL_BIT] && !wr |=> buf_info == bc0_r)
    else $error("single mode read second half");
  no_accept_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st_r != DEV_CONNECTED |-> !pkt_accept || $past(st_nxt) == DEV_CONNECTED)
    else $error("packet accepted in reset");
  conn_j_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st_r == DEV_WAIT_IDLE && st_nxt == DEV_CONNECTED |-> j_state)
    else $error("connected without idle");
  reset_sel_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ev_reset |=> !sel_r)
    else $error("select not cleared");
  break_j_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st_r == DEV_WAIT_IDLE && !j_state |-> st_nxt != DEV_CONNECTED)
    else $error("connected across break");
  c_conn: cover property (@(posedge ref_clk) ev_conn);
  c_upper: cover property (@(posedge ref_clk) done_ok && sel_r);
  c_reset: cover property (@(posedge ref_clk) ev_reset);
  c_double: cover property (@(posedge ref_clk) done_ok && ctrl_r[CTRL_DBL_BIT]);
endmodule : usb_bufsel_top
`default_nettype wire

// ==== usb_bufsel_pkg.sv ====
// constants and types for the buffer selector and reset-exit block
// How it works
// - host mode keeps one select bit choosing first or second buffer half
// - select toggles per packet; silicon also toggles it in single-buffered mode
// - split transfers above 8 bytes low speed or 64 bytes full speed
// - second-half status is written 16 bits above the first-half field
// - single-buffered fetch ignores select and reads the first half
// - attention flag records select value when a buffer is marked done
// - leave reset for connected only after 800 us unbroken J-state
// - no packet is accepted while in the reset state
// - device runs full speed, or low speed when control bit 1 is set, via translator behind high-speed hubs
// - foreign traffic more often than the idle interval keeps device in reset
// - J-state is data-plus high with data-minus low
`default_nettype none
package usb_bufsel_pkg;
  localparam int          CLK_MHZ         = 250;
  localparam int          RESET_SE0_US    = 10000;
  localparam int          RESET_SE0_CYC   = RESET_SE0_US * CLK_MHZ;
  localparam int          IDLE_J_US       = 800;
  localparam int          IDLE_J_CYC      = IDLE_J_US * CLK_MHZ;
  localparam int          LS_MAX_PKT      = 8;
  localparam int          FS_MAX_PKT      = 64;
  localparam int          STAT_W          = 16;
  localparam int          HALF_SHIFT      = 16;
  localparam int          CNT_W           = 24;
  localparam logic [7:0]  INT_RESET_BIT   = 8'h01;
  localparam logic [7:0]  INT_CONN_BIT    = 8'h02;
  localparam logic [7:0]  INT_DONE_BIT    = 8'h04;
  localparam logic [3:0]  ADDR_STATUS     = 4'h0;
  localparam logic [3:0]  ADDR_MASK       = 4'h1;
  localparam logic [3:0]  ADDR_CTRL       = 4'h2;
  localparam logic [3:0]  ADDR_EP_STAT    = 4'h3;
  localparam logic [3:0]  ADDR_ATTN       = 4'h4;
  localparam logic [3:0]  ADDR_STATE      = 4'h5;
  localparam logic [3:0]  ADDR_BUFCTL0    = 4'h6;
  localparam logic [3:0]  ADDR_BUFCTL1    = 4'h7;
  localparam int          CTRL_DBL_BIT    = 0;
  localparam int          CTRL_LS_BIT     = 1;
  localparam int          CTRL_HOST_BIT   = 2;
  typedef enum logic [1:0] {DEV_CONNECTED, DEV_RESET, DEV_WAIT_IDLE} dev_state_t;
endpackage : usb_bufsel_pkg
`default_nettype wire

// ==== usb_idle_timer.sv ====
// counter of uninterrupted line conditions
`timescale 1ns/1ps
`default_nettype none
module usb_idle_timer #(
  parameter int LIMIT = 200000,
  parameter int W     = 24
) (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic cond,
  output var  logic done
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  always_comb begin
    if (!cond) begin
      cnt_nxt = '0;
    end else if (cnt_r != W'(LIMIT)) begin
      cnt_nxt = cnt_r + W'(1);
    end else begin
      cnt_nxt = cnt_r;
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
  assign done = cond && (cnt_r == W'(LIMIT));
endmodule : usb_idle_timer
`default_nettype wire

// ==== usb_host_line.sv ====
// line model of the host or hub side of the bus
`timescale 1ns/1ps
`default_nettype none
module usb_host_line (
  input  wire logic       ref_clk,
  input  wire logic [1:0] mode,
  output logic            dp,
  output logic            dm
);
  logic [5:0] ph_r = 6'h00;
  // ----------------------------
  // foreign traffic: 4 K cycles then 30 J cycles
  // ----------------------------
  always_ff @(posedge ref_clk) begin
    ph_r <= (ph_r == 6'h21) ? 6'h00 : ph_r + 6'h01;
  end
  always_comb begin
    dp = 1'b1;
    dm = 1'b0;
    if (mode == 2'h1) begin
      dp = 1'b0;
    end else if (mode == 2'h2 && ph_r < 6'h04) begin
      dp = 1'b0;
      dm = 1'b1;
    end
  end
endmodule : usb_host_line
`default_nettype wire

// ==== testbench.sv ====
// self-checking bench for the buffer selector and reset exit
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import usb_bufsel_pkg::*;
  localparam int IDLE = 40;
  logic ref_clk, rst_n, dp_in, dm_in, pkt_done, pkt_in, wr, rd, irq, pkt_accept, buf_sel;
  logic [15:0] pkt_status, buf_info;
  logic [3:0]  addr;
  logic [31:0] wdata, rdata, d;
  logic [6:0]  max_pkt;
  logic [1:0]  mode;
  int          err_count, checked;
  usb_bufsel_top #(.RESET_CYC(20), .IDLE_CYC(IDLE)) DUT (.ref_clk(ref_clk), .rst_n(rst_n),
    .dp_in(dp_in), .dm_in(dm_in), .pkt_done(pkt_done), .pkt_in(pkt_in),
    .pkt_status(pkt_status), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .irq(irq), .pkt_accept(pkt_accept), .buf_sel(buf_sel), .buf_info(buf_info),
    .max_pkt(max_pkt));
  usb_host_line host (.ref_clk(ref_clk), .mode(mode), .dp(dp_in), .dm(dm_in));
  // ----------------------------
  // shared tasks
  // ----------------------------
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic print_verdict;
    if (err_count == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc
  task automatic wreg(input logic [3:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    wr <= 1'b1; addr <= a; wdata <= v;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [3:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    rd <= 1'b1; addr <= a;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rreg
  task automatic pkt(input logic [15:0] s);
    @(posedge ref_clk);
    pkt_done <= 1'b1; pkt_status <= s;
    @(posedge ref_clk);
    pkt_done <= 1'b0;
    #1;
  endtask : pkt
  task automatic drive_line(input logic [1:0] m);
    @(posedge ref_clk);
    mode <= m;
    #1;
  endtask : drive_line
  task automatic wait_conn(input int pre);
    int n;
    for (n = 0; n < 120 && pkt_accept !== 1'b1; n++) cyc(1);
    if (n == 120) begin
      chk("connect_timeout", 0, 1);
      print_verdict();
    end
    chk("connect_time", 32'(n + pre >= IDLE && n + pre <= IDLE + 10), 1);
    rreg(ADDR_STATE, d);
    chk("state", d[1:0], 2'h0);
  endtask : wait_conn
  // ----------------------------
  // scenarios
  // ----------------------------
  task automatic t_exit;
    cyc(IDLE / 2);
    chk("accept_early", pkt_accept, 0);
    wait_conn(IDLE / 2);
    @(posedge ref_clk);
    pkt_in <= 1'b0;
    cyc(1);
    chk("accept_idle", pkt_accept, 0);
    @(posedge ref_clk);
    pkt_in <= 1'b1;
  endtask : t_exit
  task automatic t_regs;
    wreg(ADDR_BUFCTL0, 32'h0000_1234);
    wreg(ADDR_BUFCTL1, 32'h0000_5678);
    wreg(ADDR_CTRL, 32'h0000_0002);
    cyc(2);
    chk("max_ls", max_pkt, 8);
    wreg(ADDR_CTRL, 32'h0000_0000);
    cyc(2);
    chk("max_fs", max_pkt, 64);
    pkt(16'h00ff);
    chk("host_off", buf_sel, 0);
    rreg(4'hf, d);
    chk("unmapped", d, 0);
  endtask : t_regs
  task automatic t_bufsel;
    wreg(ADDR_CTRL, 32'h1 << CTRL_HOST_BIT);
    wreg(ADDR_MASK, 32'(INT_DONE_BIT));
    pkt(16'h00a5);
    chk("sel_single", buf_sel, 1);
    rreg(ADDR_EP_STAT, d);
    chk("ep_first", d, 32'h0000_00a5);
    rreg(ADDR_ATTN, d);
    chk("attn_first", d, 32'h1);
    chk("info_single", buf_info, 16'h1234);
    chk("irq_set", irq, 1);
    pkt(16'h005a);
    chk("sel_back", buf_sel, 0);
    rreg(ADDR_EP_STAT, d);
    chk("ep_second", d, 32'h005a_00a5);
    rreg(ADDR_ATTN, d);
    chk("attn_both", d, 32'h3);
    wreg(ADDR_STATUS, 32'(INT_DONE_BIT));
    cyc(2);
    chk("irq_clear", irq, 0);
    wreg(ADDR_CTRL, (32'h1 << CTRL_HOST_BIT) | (32'h1 << CTRL_DBL_BIT));
    pkt(16'h0011);
    cyc(1);
    chk("info_double", buf_info, 16'h5678);
  endtask : t_bufsel
  task automatic t_busreset;
    drive_line(2'h1);
    cyc(30);
    chk("accept_reset", pkt_accept, 0);
    chk("sel_reset", buf_sel, 0);
    rreg(ADDR_STATUS, d);
    chk("reset_event", d & 32'(INT_RESET_BIT), 32'(INT_RESET_BIT));
    rreg(ADDR_STATE, d);
    chk("state_reset", d[2:0], 3'h1);
  endtask : t_busreset
  task automatic t_traffic;
    int hits;
    hits = 0;
    drive_line(2'h2);
    repeat (300) begin
      cyc(1);
      if (pkt_accept !== 1'b0) hits++;
    end
    chk("busy_hold", hits, 0);
    drive_line(2'h1);
    cyc(2);
    drive_line(2'h0);
    wait_conn(0);
  endtask : t_traffic
  // ----------------------------
  // clock, reset and main sequence
  // ----------------------------
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  initial begin
    err_count = 0; checked = 0; rst_n = 1'b0; mode = 2'h0; pkt_done = 1'b0; pkt_in = 1'b1;
    pkt_status = 16'h0000; addr = 4'h0; wdata = 32'h0; wr = 1'b0; rd = 1'b0;
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_exit();
    t_regs();
    t_bufsel();
    t_busreset();
    t_traffic();
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
